// ---- design/sdsi_device.sv ----
// sdsi_device: setpoint input end that turns step pulses into position
`timescale 1ns/1ps

// Summary of operation
// - mode input picks step/dir or twin step
// - step/dir mode: one step per strobe rise while the amplifier is on
// - direction low gives cw, high gives ccw
// - twin mode: forward rise cw, backward ccw
// - source keeps step rate at most 200 kHz
// - amplifier enabled only while enable is high
// - ready goes low no sooner than 100 ms after enable
// - ready high when disabled, low when enabled
// - fault holds ready output high
// - reserved function output held low
// - single-ended sources stay below 50 kHz (SE_HALF_CYC is defined but the host does not use it)
module sdsi_device
   import sdsi_pkg::*;
#(
   parameter int unsigned READY_CYC = READY_DELAY_CYC
) (
   input wire logic i_core_clk,              // 50 MHz core clock
   input wire logic i_resetn,                // async reset, active low
   input wire logic i_setpoint_mode_param,   // 0 step/dir, 1 twin step
   input wire logic i_fault,                 // operating fault present
   sdsi_if.device link,                      // link to motion controller
   output logic o_amp_on,                    // power amplifier enabled
   output logic o_drive_ready_true,          // drive ready, active high
   output logic o_step_pulse,                // one-cycle step event
   output logic o_step_ccw,                  // direction of that step
   output logic signed [POS_W-1:0] o_position // position setpoint
);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sync1_q, sync1_d;
   logic [2:0] sync2_q, sync2_d;
   logic [1:0] prev_q, prev_d;

   // first stage is read only by the second stage
   always_comb begin
      sync1_d = {link.amp_enable, link.step_backward_in,
                 link.step_forward_in};
      sync2_d = sync1_q;
      prev_d = sync2_q[1:0];
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         prev_q <= 2'h0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q <= prev_d;
      end
   end

   // ----------------------------------------------------------------
   // edge detection
   // ----------------------------------------------------------------
   // both step lines use the same rising edge test on synchronised
   // levels; the previous-level flops reset low like an idle line, so
   // a line held high through reset does show one rise afterwards
   function automatic logic rose_f(input logic now_l, input logic was_l);
      return now_l & ~was_l;
   endfunction

   // ----------------------------------------------------------------
   // step decoding and accumulator
   // ----------------------------------------------------------------
   // the accumulator wraps silently at its width; a user who needs
   // longer travel widens it through the package width
   logic rise_fwd, rise_bwd, en_s;
   logic signed [POS_W-1:0] pos_q, pos_d;
   logic amp_q, amp_d;
   logic step_q, step_d;
   logic ccw_q, ccw_d;
   logic ready_q, ready_d;
   logic [31:0] cnt_q, cnt_d;

   // rises are taken only from the second synchroniser stage
   assign rise_fwd = rose_f(sync2_q[0], prev_q[0]);
   assign rise_bwd = rose_f(sync2_q[1], prev_q[1]);
   assign en_s = sync2_q[2];

   // next position, step event and direction
   always_comb begin
      step_d = 1'b0;
      ccw_d = ccw_q;
      pos_d = pos_q;
      if (i_setpoint_mode_param == MODE_STEP_DIR) begin
         if (rise_fwd) begin
            step_d = 1'b1;
            ccw_d = (sync2_q[1] == DIR_CCW);
         end
      end else begin
         // simultaneous forward and backward rises cancel out
         if (rise_fwd ^ rise_bwd) begin
            step_d = 1'b1;
            ccw_d = rise_bwd;
         end
      end
      if (!amp_q) begin
         step_d = 1'b0;
      end
      if (step_d) begin
         if (ccw_d) begin
            pos_d = pos_q - POS_W'(1);
         end else begin
            pos_d = pos_q + POS_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // amplifier enable and readiness
   // ----------------------------------------------------------------
   // the amplifier follows the synchronised enable unless a fault is
   // present; the ready delay counter restarts whenever the amplifier
   // drops, so a short enable glitch never reports readiness early.
   // ready is withheld at once on fault or on a low enable, without
   // waiting for the amplifier flop, so the controller sees not-ready
   // no later than the amplifier switches off.
   // hazard: a fault cleared in the same cycle as enable falls may let
   // the amplifier run for the two cycles of enable latency; ready
   // stays off during that time because the counter restarted.
   always_comb begin
      amp_d = en_s & ~i_fault;
      cnt_d = cnt_q;
      ready_d = 1'b0;
      if (!amp_q) begin
         cnt_d = 32'h0;
      end else if (cnt_q < READY_CYC - 1) begin
         cnt_d = cnt_q + 32'h1;
      end else begin
         ready_d = 1'b1;
      end
      if (i_fault || !en_s) begin
         ready_d = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pos_q <= '0;
         step_q <= 1'b0;
         ccw_q <= 1'b0;
         amp_q <= 1'b0;
         cnt_q <= 32'h0;
         ready_q <= 1'b0;
      end else begin
         pos_q <= pos_d;
         step_q <= step_d;
         ccw_q <= ccw_d;
         amp_q <= amp_d;
         cnt_q <= cnt_d;
         ready_q <= ready_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // every output and link line below is a flop, the inverse of one, or a constant, so the
   // far end never sees combinational glitches on the ready line
   assign o_position = pos_q;
   assign o_step_pulse = step_q;
   assign o_step_ccw = ccw_q;
   assign o_amp_on = amp_q;
   assign o_drive_ready_true = ready_q;
   assign link.drive_ready_n = ~ready_q;
   assign link.reserved_func_output = 1'b0;

endmodule // sdsi_device

// ---- design/sdsi_host.sv ----
// sdsi_host: motion controller end that issues step pulses
`timescale 1ns/1ps
module sdsi_host
   import sdsi_pkg::*;
#(
   parameter int unsigned HALF_CYC = STEP_HALF_CYC
) (
   input wire logic i_core_clk,          // 50 MHz core clock
   input wire logic i_resetn,            // async reset, active low
   input wire logic i_twin_step_mode,    // 0 step/dir, 1 twin step
   input wire logic i_enable,            // request amplifier enable
   input wire logic i_step_req,          // pulse: request one step
   input wire logic i_step_ccw,          // direction for that request
   sdsi_if.host link,                    // link to setpoint input
   output logic o_busy,                  // step in progress
   output logic o_drive_ready_true       // far drive is ready
);

   // ----------------------------------------------------------------
   // step pulse generator
   // ----------------------------------------------------------------
   sdsi_gen_e st_q, st_d;
   logic [15:0] tmr_q, tmr_d;
   logic fwd_q, fwd_d, bwd_q, bwd_d, ccw_q, ccw_d;
   logic en_q, en_d, rdy_q, rdy_d;

   // each phase lasts HALF_CYC so the rate stays at or below the limit
   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      fwd_d = fwd_q;
      bwd_d = bwd_q;
      ccw_d = ccw_q;
      en_d = i_enable;
      rdy_d = ~link.drive_ready_n;
      if (tmr_q != 16'h0) begin
         tmr_d = tmr_q - 16'h1;
      end
      case (st_q)
         SDSI_IDLE: begin
            if (i_step_req) begin
               ccw_d = i_step_ccw;
               if (!i_twin_step_mode) begin
                  bwd_d = i_step_ccw;
               end
               tmr_d = 16'(HALF_CYC - 1);
               st_d = SDSI_SETUP;
            end
         end
         SDSI_SETUP: begin
            if (tmr_q == 16'h0) begin
               if (i_twin_step_mode && ccw_q) begin
                  bwd_d = 1'b1;
               end else begin
                  fwd_d = 1'b1;
               end
               tmr_d = 16'(HALF_CYC - 1);
               st_d = SDSI_HIGH;
            end
         end
         SDSI_HIGH: begin
            if (tmr_q == 16'h0) begin
               fwd_d = 1'b0;
               if (i_twin_step_mode) begin
                  bwd_d = 1'b0;
               end
               tmr_d = 16'(HALF_CYC - 1);
               st_d = SDSI_LOW;
            end
         end
         default: begin
            if (tmr_q == 16'h0) begin
               st_d = SDSI_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= SDSI_IDLE;
         tmr_q <= 16'h0;
         fwd_q <= 1'b0;
         bwd_q <= 1'b0;
         ccw_q <= 1'b0;
         en_q <= 1'b0;
         rdy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         fwd_q <= fwd_d;
         bwd_q <= bwd_d;
         ccw_q <= ccw_d;
         en_q <= en_d;
         rdy_q <= rdy_d;
      end
   end

   assign link.step_forward_in = fwd_q;
   assign link.step_backward_in = bwd_q;
   assign link.amp_enable = en_q;
   assign o_busy = (st_q != SDSI_IDLE);
   assign o_drive_ready_true = rdy_q;

endmodule // sdsi_host

// ---- design/sdsi_if.sv ----
// sdsi_if: link wires between motion controller and setpoint input
`timescale 1ns/1ps
interface sdsi_if;
   logic step_forward_in;     // step strobe, or forward step
   logic step_backward_in;    // direction, or backward step
   logic amp_enable;          // high enables the power amplifier
   logic drive_ready_n;       // low when drive is ready
   logic reserved_func_output; // always low from device

   modport device (
      input step_forward_in,
      input step_backward_in,
      input amp_enable,
      output drive_ready_n,
      output reserved_func_output
   );
   modport host (
      output step_forward_in,
      output step_backward_in,
      output amp_enable,
      input drive_ready_n,
      input reserved_func_output
   );
endinterface : sdsi_if

// ---- design/sdsi_pkg.sv ----
// sdsi_pkg: shared constants and types for the step/direction setpoint link
package sdsi_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned READY_DELAY_MS = 100;
   localparam int unsigned READY_DELAY_CYC = CLK_HZ / 1000 * READY_DELAY_MS;
   localparam int unsigned STEP_MAX_HZ = 200_000;
   // half period of the fastest permitted step rate, in cycles
   localparam int unsigned STEP_HALF_CYC = CLK_HZ / (2 * STEP_MAX_HZ);
   localparam int unsigned SE_MAX_HZ = 50_000;
   localparam int unsigned SE_HALF_CYC = CLK_HZ / (2 * SE_MAX_HZ);

   // ----------------------------------------------------------------
   // widths and modes
   // ----------------------------------------------------------------
   localparam int unsigned POS_W = 32;
   localparam int unsigned SYNC_STAGES = 2;
   localparam logic [0:0] MODE_STEP_DIR = 1'h0;
   localparam logic [0:0] MODE_TWIN_STEP = 1'h1;

   // direction encoding on the sense line
   localparam logic DIR_CW = 1'b0;
   localparam logic DIR_CCW = 1'b1;

   // host pulse generator states, gray along the usual path
   typedef enum logic [1:0] {
      SDSI_IDLE = 2'b00,
      SDSI_SETUP = 2'b01,
      SDSI_HIGH = 2'b11,
      SDSI_LOW = 2'b10
   } sdsi_gen_e;

endpackage : sdsi_pkg

// ---- verification/sdsi_properties.sv ----
// sdsi_properties: link checks between motion controller and drive end
`timescale 1ns/1ps
module sdsi_properties (
   input wire logic i_core_clk, // core clock
   input wire logic i_resetn, // reset, active low
   input wire logic step_forward_in, // strobe or forward step
   input wire logic step_backward_in, // sense or backward step
   input wire logic amp_enable, // amplifier enable
   input wire logic drive_ready_n, // ready, active low
   input wire logic reserved_func_output // reserved, held low
);
   // ----------------------------------------
   // link checks, host half period of 4
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);
   // strobe high for a half period, then released
   sequence s_pulse;
      step_forward_in [*3] ##[1:3] !step_forward_in;
   endsequence
   step_shape_a: assert property ($rose(step_forward_in) |-> s_pulse)
      else $error("step strobe width wrong");
   step_gap_a: assert property ($fell(step_forward_in) |->
      !step_forward_in [*3]) else $error("step strobe low too short");
   back_gap_a: assert property ($fell(step_backward_in) |->
      !step_backward_in [*3]) else $error("backward line low too short");
   dir_setup_a: assert property ($rose(step_forward_in) |->
      step_backward_in == $past(step_backward_in, 3))
      else $error("sense changed near strobe");
   resv_low_a: assert property (!reserved_func_output)
      else $error("reserved output not low");
   ready_drop_a: assert property ($fell(amp_enable) |->
      ##[0:4] drive_ready_n) else $error("ready kept after disable");
   ready_idle_a: assert property (!amp_enable [*5] |-> drive_ready_n)
      else $error("ready while disabled");
   ready_hold_a: assert property ($rose(amp_enable) |->
      drive_ready_n [*8]) else $error("ready before delay");
endmodule // sdsi_properties

// ---- verification/step_direction_setpoint_input_tb_top.sv ----
// step_direction_setpoint_input_tb_top: bench joining both link ends
`timescale 1ns/1ps
module step_direction_setpoint_input_tb_top
   import sdsi_pkg::*;
;
   // ----------------------------------------
   // signals, ends and checker
   // ----------------------------------------
   localparam int READY_N = 20; // shortened ready delay
   typedef struct packed {
      logic mode;
      logic ccw;
      logic [31:0] delta;
   } sdsi_row_s;
   logic core_clk, resetn, mode, enable, step_req, step_ccw, fault;
   logic busy, host_ready, amp_on, dev_ready, step_pulse, last_ccw;
   logic signed [POS_W-1:0] position;
   logic [31:0] pos_exp;
   int error_cnt, check_count, n, pulse_cnt;
   sdsi_row_s rows [4];
   sdsi_if link ();
   sdsi_host #(.HALF_CYC(4)) i_sdsi_host (.i_core_clk(core_clk),
      .i_resetn(resetn), .i_twin_step_mode(mode), .i_enable(enable),
      .i_step_req(step_req), .i_step_ccw(step_ccw), .link(link.host),
      .o_busy(busy), .o_drive_ready_true(host_ready));
   sdsi_device #(.READY_CYC(READY_N)) i_sdsi_device (.i_core_clk(core_clk),
      .i_resetn(resetn), .i_setpoint_mode_param(mode), .i_fault(fault),
      .link(link.device), .o_amp_on(amp_on), .o_drive_ready_true(dev_ready),
      .o_step_pulse(step_pulse), .o_step_ccw(last_ccw), .o_position(position));
   sdsi_properties i_sdsi_properties (.i_core_clk(core_clk),
      .i_resetn(resetn), .step_forward_in(link.step_forward_in),
      .step_backward_in(link.step_backward_in), .amp_enable(link.amp_enable),
      .drive_ready_n(link.drive_ready_n),
      .reserved_func_output(link.reserved_func_output));
   // compare, verdict and one host step
   task automatic chk(input logic [31:0] seen, exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic do_step(input logic c);
      @(posedge core_clk);
      step_req <= 1'h1;
      step_ccw <= c;
      @(posedge core_clk);
      step_req <= 1'h0;
      repeat (40) begin
         @(negedge core_clk);
         if (busy === 1'h0) break;
      end
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   // count one-cycle step events from the device
   always @(posedge core_clk) begin
      if (step_pulse === 1'h1) pulse_cnt++;
   end
   // clock and watchdog
   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      repeat (6000) @(posedge core_clk);
      error_cnt++;
      end_of_test();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rows = '{'{1'h0, 1'h0, 32'h1}, '{1'h0, 1'h1, 32'hFFFFFFFF},
         '{1'h1, 1'h0, 32'h1}, '{1'h1, 1'h1, 32'hFFFFFFFF}};
      {resetn, mode, enable, step_req, step_ccw, fault} = '0;
      error_cnt = 0;
      check_count = 0;
      pulse_cnt = 0;
      pos_exp = '0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'h1;
      @(negedge core_clk);
      chk(link.drive_ready_n, 1'h1, "ready at reset");
      chk(link.reserved_func_output, 1'h0, "reserved output");
      do_step(1'h0);
      chk(position, 32'h0, "counted while disabled");
      @(posedge core_clk);
      enable <= 1'h1;
      n = 0;
      repeat (60) begin
         @(negedge core_clk);
         if (link.drive_ready_n === 1'h0) break;
         n++;
      end
      chk(n >= READY_N && n <= READY_N + 8, 1'h1, "ready delay");
      chk(amp_on, 1'h1, "amplifier on");
      chk(dev_ready, 1'h1, "device ready");
      foreach (rows[i]) begin
         @(posedge core_clk);
         mode <= rows[i].mode;
         do_step(rows[i].ccw);
         pos_exp = pos_exp + rows[i].delta;
         chk(position, pos_exp, "position after step");
         chk(last_ccw, rows[i].ccw, "step sense");
      end
      // request held over two edges: the busy host takes one
      @(posedge core_clk);
      step_req <= 1'h1;
      step_ccw <= 1'h0;
      repeat (2) @(posedge core_clk);
      step_req <= 1'h0;
      repeat (30) @(negedge core_clk);
      pos_exp = pos_exp + 32'h1;
      chk(position, pos_exp, "one count per request");
      chk(host_ready, 1'h1, "host sees ready");
      @(posedge core_clk);
      fault <= 1'h1;
      repeat (4) @(negedge core_clk);
      chk(link.drive_ready_n, 1'h1, "ready under fault");
      chk(amp_on, 1'h0, "amplifier under fault");
      do_step(1'h1);
      chk(position, pos_exp, "counted under fault");
      @(posedge core_clk);
      fault <= 1'h0;
      enable <= 1'h0;
      repeat (6) @(negedge core_clk);
      chk(link.drive_ready_n, 1'h1, "ready after disable");
      chk(host_ready, 1'h0, "host ready after disable");
      chk(pulse_cnt, 32'h5, "step event count");
      // mid-run reset clears the accumulator and readiness
      @(posedge core_clk);
      resetn <= 1'h0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'h1;
      repeat (2) @(negedge core_clk);
      chk(position, 32'h0, "position after reset");
      chk(link.drive_ready_n, 1'h1, "ready after reset");
      chk(step_pulse, 1'h0, "no step after reset");
      end_of_test();
   end
endmodule // step_direction_setpoint_input_tb_top
